// ---- src/agcpm_pin_mux.sv ----
// top: address/port pin mux, clock output select and oscillator mode
//
// Behaviour
// [RL1] drive low six address lines in address function
// [RL2] pins come up as address bus
// [RL3] port pins individually input or output
// [RL4] clear pull-up bit at port index disables
// [RL5] idle bus floats pins unless drive bit
// [RL6] clock output source chosen by select register
// [RL7] oscillator clock feeds core or pll reference
// [RL8] board drives external clock, grounds input pin
// [RL9] clock mode pin picks external clock/crystal
// [RL10] per-pin function bit, reset to address
//
// register map, byte offsets on the wishbone slave
// 00 function select, bits 13:8, one bit per pin
//    set bit keeps the pin on the address bus
//    cleared bit hands the pin to the port logic
// 04 port direction, bits 13:8, set means output
// 08 port output level, bits 13:8
// 0c port input level, bits 13:8, read only
//    value is the pad level after two sync flops
// 10 pull-up enable, bits 13:8
//    index of the bit equals the port bit number
//    so pin 0 sits on port bit 8 and uses bit 8
// 14 bus control, bit 0 is the drive bit
//    cleared: address pins float while bus idle
//    set: address pins drive at all times
//    software should normally set it after boot
// 18 clock output select, bits 2:0
//    0 off, pin released and held low
//    1 main system clock
//    2 peripheral bus clock
//    3 oscillator output
//    4 prescaler clock
//    5 postscaler clock
//    6 and 7 test signals
// 1c clock configuration
//    bit 0 oscillator clock as pll reference
//    bit 1 synchronised mode pin, read only
// every other bit and offset reads as zero
// writes to read-only or unmapped offsets are dropped
//
// bus timing
// a request is taken on the edge where cyc and stb
// are high and ack is low; ack is a one cycle pulse
// in the following cycle, read data stands with it
// and is kept until the next access
// a write lands on the taking edge, so a read that
// follows at once already sees the new value
// byte lanes of sel mask writes, reads return all
//
// pad timing
// every pad output leaves a flop, so pads follow
// a configuration change one edge after it lands
// address bits and the bus-active flag also pass
// one flop, which the memory side must allow for
//
// clock output
// the selected level passes one flop, so the pin
// shows a copy of the source one cycle late
// sources are sampled on the block clock, so only
// sources slower than half that rate come out clean
//
// oscillator
// the mode pin is a static strap; it still passes
// two flops since it comes from outside the domain
// the crystal amplifier is off while the strap is
// high, as then an external clock drives the pin
// grounding the crystal input is left to the board
//
// reset
// rst_b asserts at once and releases through two
// flops; every pin comes up floating with pull-up
// on, on the address bus, with clock output off
// the first bus request may come on the third edge
// after release
`timescale 1ns/10ps
module agcpm_pin_mux
   import agcpm_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // wishbone slave
   input wire agcpm_pkg::agcpm_wb_req_s wbReq,
   output agcpm_pkg::agcpm_wb_rsp_s wbRsp,
   // external memory interface
   input wire logic [agcpm_pkg::NUM_PINS-1:0] emiAddr,
   input wire logic emiBusActive,
   output logic emiCtrlOe_b,
   // shared pads
   input wire logic [agcpm_pkg::NUM_PINS-1:0] padIn,
   output agcpm_pkg::agcpm_pad_s pad,
   // clock output pin
   input wire agcpm_pkg::agcpm_clk_src_s clkSrc,
   output logic clockOutputPin,
   output logic clockOutputPinOe_b,
   // oscillator control
   input wire logic clockInputModePin,
   output logic oscAmpEnable,
   output logic coreClkFromPll
);
   import agcpm_pkg::*;

   // state of the block apart from the reset synchroniser
   typedef struct packed {
      logic ack;
      logic [31:0] rdData;
      logic [NUM_PINS-1:0] funcSel;
      logic [NUM_PINS-1:0] portDir;
      logic [NUM_PINS-1:0] portOut;
      logic [NUM_PINS-1:0] pullEn;
      logic drvBit;
      logic [2:0] clkoSel;
      logic pllRef;
      logic [NUM_PINS-1:0] inMeta;
      logic [NUM_PINS-1:0] inSync;
      logic modeMeta;
      logic modeSync;
      agcpm_pad_s pad;
      logic ctrlOe_b;
      logic clkOut;
      logic clkOutOe_b;
      logic oscAmp;
      logic corePll;
   } agcpm_state_s;

   localparam agcpm_state_s RST_STATE = '{
      ack: 1'b0,
      rdData: 32'h0000_0000,
      funcSel: RST_FUNC_SEL,
      portDir: RST_PORT_DIR,
      portOut: RST_PORT_OUT,
      pullEn: RST_PULLUP,
      drvBit: RST_DRV,
      clkoSel: RST_CLOCK_OUTPUT_PIN_SEL,
      pllRef: RST_PLL_REF,
      inMeta: 6'h00,
      inSync: 6'h00,
      modeMeta: 1'b0,
      modeSync: 1'b0,
      pad: '{out: 6'h00, oe_b: 6'h3F, pullEn: RST_PULLUP},
      ctrlOe_b: 1'b1,
      clkOut: 1'b0,
      clkOutOe_b: 1'b1,
      oscAmp: 1'b0,
      corePll: 1'b0
   };

   // reset release synchroniser
   logic [1:0] rstSync_ff;
   logic rstLocal_b;
   // registered state and its next value
   agcpm_state_s state_ff;
   agcpm_state_s nxt_state;
   // per-pin cell results
   logic [NUM_PINS-1:0] cellOut;
   logic [NUM_PINS-1:0] cellOe_b;
   // clock output selector results
   logic clkoLevel;
   logic clkoEnable;
   // bus decode helpers
   logic busReq;
   logic [31:0] wrMask;
   logic [31:0] curWord;
   logic [31:0] newWord;

   assign rstLocal_b = rstSync_ff[1];

   // async assert, release through two flops
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_ff <= 2'b00;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end

   // one cell per shared pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         agcpm_pin_cell u_cell (
            .addrFunc(state_ff.funcSel[gi]),
            .drvBit(state_ff.drvBit),
            .portDir(state_ff.portDir[gi]),
            .portOut(state_ff.portOut[gi]),
            .busActive(emiBusActive),
            .addrBit(emiAddr[gi]),
            .padOut(cellOut[gi]),
            .padOe_b(cellOe_b[gi])
         );
      end
   endgenerate

   // clock output source selector
   agcpm_clkout_sel u_clock_output_pin (
      .sel(state_ff.clkoSel),
      .src(clkSrc),
      .level(clkoLevel),
      .enable(clkoEnable)
   );

   // byte lane mask from wishbone select
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wrMask[b*8 +: 8] = {8{wbReq.sel[b]}};
      end
   end

   assign busReq = wbReq.cyc && wbReq.stb && !state_ff.ack;

   // read view of the addressed register; unmapped reads zero
   always_comb begin
      curWord = 32'h0000_0000;
      case (wbReq.adr)
         OFS_FUNC_SEL: curWord[PORT_BASE +: NUM_PINS] = state_ff.funcSel;
         OFS_PORT_DIR: curWord[PORT_BASE +: NUM_PINS] = state_ff.portDir;
         OFS_PORT_OUT: curWord[PORT_BASE +: NUM_PINS] = state_ff.portOut;
         OFS_PORT_IN: curWord[PORT_BASE +: NUM_PINS] = state_ff.inSync;
         OFS_PULLUP: curWord[PORT_BASE +: NUM_PINS] = state_ff.pullEn;
         OFS_BUS_CTRL: curWord[DRV_BIT_POS] = state_ff.drvBit;
         OFS_CLOCK_OUTPUT_PIN_SEL: curWord[2:0] = state_ff.clkoSel;
         OFS_CLK_CFG: begin
            curWord[PLL_REF_POS] = state_ff.pllRef;
            curWord[MODE_STAT_POS] = state_ff.modeSync; // [RL9]
         end
         default: curWord = 32'h0000_0000;
      endcase
   end

   // merged word for a write, only lanes that sel enables
   assign newWord = (curWord & ~wrMask) | (wbReq.dat & wrMask);

   // next state: bus access, synchronisers, pad and clock outputs
   always_comb begin
      nxt_state = state_ff;
      // ack for one cycle, dropped the cycle after
      nxt_state.ack = busReq;
      if (busReq) begin
         nxt_state.rdData = curWord;
      end
      // write takes effect on the same edge that raises ack
      if (busReq && wbReq.we) begin
         case (wbReq.adr)
            OFS_FUNC_SEL: nxt_state.funcSel = newWord[PORT_BASE +: NUM_PINS]; // [RL10]
            OFS_PORT_DIR: nxt_state.portDir = newWord[PORT_BASE +: NUM_PINS]; // [RL3]
            OFS_PORT_OUT: nxt_state.portOut = newWord[PORT_BASE +: NUM_PINS]; // [RL3]
            OFS_PULLUP: nxt_state.pullEn = newWord[PORT_BASE +: NUM_PINS]; // [RL4]
            OFS_BUS_CTRL: nxt_state.drvBit = newWord[DRV_BIT_POS]; // [RL5]
            OFS_CLOCK_OUTPUT_PIN_SEL: nxt_state.clkoSel = newWord[2:0]; // [RL6]
            OFS_CLK_CFG: nxt_state.pllRef = newWord[PLL_REF_POS]; // [RL7]
            // port input and unmapped offsets ignore writes
            default: nxt_state.pllRef = state_ff.pllRef;
         endcase
      end
      // pad and mode pin synchronisers, first stage read only by second
      nxt_state.inMeta = padIn;
      nxt_state.inSync = state_ff.inMeta;
      nxt_state.modeMeta = clockInputModePin;
      nxt_state.modeSync = state_ff.modeMeta;
      // pads registered so every output leaves a flop
      nxt_state.pad.out = cellOut; // [RL1]
      nxt_state.pad.oe_b = cellOe_b; // [RL5]
      nxt_state.pad.pullEn = state_ff.pullEn; // [RL4]
      // control strobes follow the same idle float policy
      nxt_state.ctrlOe_b = !(emiBusActive || state_ff.drvBit); // [RL5]
      // one register stage of delay on the clock output level
      nxt_state.clkOut = clkoLevel; // [RL6]
      nxt_state.clkOutOe_b = !clkoEnable; // [RL6]
      // crystal amplifier off when an external clock drives the input
      nxt_state.oscAmp = !state_ff.modeSync; // [RL9]
      nxt_state.corePll = state_ff.pllRef; // [RL7]
   end

   // single state register, reset holds pins in address function
   always_ff @(posedge clock or negedge rstLocal_b) begin
      if (!rstLocal_b) begin
         state_ff <= RST_STATE; // [RL2]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs straight from the state register
   assign wbRsp.ack = state_ff.ack;
   assign wbRsp.dat = state_ff.rdData;
   assign pad = state_ff.pad;
   assign emiCtrlOe_b = state_ff.ctrlOe_b;
   assign clockOutputPin = state_ff.clkOut;
   assign clockOutputPinOe_b = state_ff.clkOutOe_b;
   assign oscAmpEnable = state_ff.oscAmp;
   assign coreClkFromPll = state_ff.corePll;
endmodule // agcpm_pin_mux

// ---- src/agcpm_pkg.sv ----
// package with offsets, reset values, encodings and carriers of the pin mux
package agcpm_pkg;
   // pin count and their place inside port a
   localparam int NUM_PINS = 6;
   localparam int PORT_BASE = 8;
   localparam int ADR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
   localparam logic [7:0] OFS_PORT_DIR = 8'h04;
   localparam logic [7:0] OFS_PORT_OUT = 8'h08;
   localparam logic [7:0] OFS_PORT_IN = 8'h0C;
   localparam logic [7:0] OFS_PULLUP = 8'h10;
   localparam logic [7:0] OFS_BUS_CTRL = 8'h14;
   localparam logic [7:0] OFS_CLOCK_OUTPUT_PIN_SEL = 8'h18;
   localparam logic [7:0] OFS_CLK_CFG = 8'h1C;
   // field positions
   localparam int DRV_BIT_POS = 0;
   localparam int PLL_REF_POS = 0;
   localparam int MODE_STAT_POS = 1;
   // values after reset
   localparam logic [5:0] RST_FUNC_SEL = 6'h3F;
   localparam logic [5:0] RST_PORT_DIR = 6'h00;
   localparam logic [5:0] RST_PORT_OUT = 6'h00;
   localparam logic [5:0] RST_PULLUP = 6'h3F;
   localparam logic RST_DRV = 1'b0;
   localparam logic [2:0] RST_CLOCK_OUTPUT_PIN_SEL = 3'h0;
   localparam logic RST_PLL_REF = 1'b0;
   // clock output source codes
   localparam logic [2:0] CLOCK_OUTPUT_PIN_OFF = 3'h0;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_MAIN = 3'h1;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_PERIPH = 3'h2;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_OSC = 3'h3;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_PRESC = 3'h4;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_POSTSC = 3'h5;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_TEST0 = 3'h6;
   localparam logic [2:0] CLOCK_OUTPUT_PIN_TEST1 = 3'h7;
   // wishbone request from master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } agcpm_wb_req_s;
   // wishbone answer to master
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } agcpm_wb_rsp_s;
   // pad drive of the six shared pins
   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe_b;
      logic [NUM_PINS-1:0] pullEn;
   } agcpm_pad_s;
   // clock source levels from the clock generator
   typedef struct packed {
      logic mainClk;
      logic periphClk;
      logic oscClk;
      logic prescClk;
      logic postscClk;
      logic test0;
      logic test1;
   } agcpm_clk_src_s;
endpackage

// ---- src/agcpm_pin_cell.sv ----
// one shared pin: address function or port bit, with idle float policy
`timescale 1ns/10ps
module agcpm_pin_cell (
   // configuration
   input wire logic addrFunc,
   input wire logic drvBit,
   input wire logic portDir,
   input wire logic portOut,
   // external memory side
   input wire logic busActive,
   input wire logic addrBit,
   // pad drive
   output logic padOut,
   output logic padOe_b
);
   // pad decision, active low enable
   always_comb begin
      if (addrFunc) begin
         padOut = addrBit; // [RL1]
         // float while idle unless drive bit is set
         padOe_b = !(busActive || drvBit); // [RL5]
      end else begin
         padOut = portOut; // [RL3]
         padOe_b = !portDir; // [RL3]
      end
   end
endmodule // agcpm_pin_cell

// ---- src/agcpm_clkout_sel.sv ----
// source selector for the buffered clock output pin
`timescale 1ns/10ps
module agcpm_clkout_sel
   import agcpm_pkg::*;
(
   // selection
   input wire logic [2:0] sel,
   input wire agcpm_pkg::agcpm_clk_src_s src,
   // selected level
   output logic level,
   output logic enable
);
   import agcpm_pkg::*;

   // plain case, off drives low and disables the pin
   always_comb begin
      enable = 1'b1;
      case (sel) // [RL6]
         CLOCK_OUTPUT_PIN_MAIN: level = src.mainClk;
         CLOCK_OUTPUT_PIN_PERIPH: level = src.periphClk;
         CLOCK_OUTPUT_PIN_OSC: level = src.oscClk;
         CLOCK_OUTPUT_PIN_PRESC: level = src.prescClk;
         CLOCK_OUTPUT_PIN_POSTSC: level = src.postscClk;
         CLOCK_OUTPUT_PIN_TEST0: level = src.test0;
         CLOCK_OUTPUT_PIN_TEST1: level = src.test1;
         default: begin
            level = 1'b0;
            enable = 1'b0;
         end
      endcase
   end
endmodule // agcpm_clkout_sel

// ---- test/agcpm_pin_mux_monitor.sv ----
// checker on the pin mux top ports
`timescale 1ns/10ps
module agcpm_pin_mux_monitor
   import agcpm_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // bus
   input wire agcpm_pkg::agcpm_wb_req_s wbReq,
   input wire agcpm_pkg::agcpm_wb_rsp_s wbRsp,
   // memory side and pads
   input wire logic emiBusActive,
   input wire logic emiCtrlOe_b,
   input wire agcpm_pkg::agcpm_pad_s pad,
   // clocking
   input wire logic clockOutputPin,
   input wire logic clockOutputPinOe_b,
   input wire logic clockInputModePin,
   input wire logic oscAmpEnable,
   input wire logic coreClkFromPll
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // taken request is answered next cycle, as a pulse
   property p_ack_req; wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack; endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack missing");
   property p_ack_pulse; wbRsp.ack |=> !wbRsp.ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause; wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   // strobes must drive while an access runs
   property p_busy_drive; $past(emiBusActive) |-> !emiCtrlOe_b; endproperty
   a_busy_drive: assert property (p_busy_drive) else $error("strobes float");
   // disabled clock output is low and released
   property p_clock_output_pin_off; clockOutputPinOe_b |-> !clockOutputPin; endproperty
   a_clock_output_pin_off: assert property (p_clock_output_pin_off) else $error("clock out off");
   // strap settles within a few cycles
   property p_osc_amp; $stable(clockInputModePin) [*8] |-> oscAmpEnable == !clockInputModePin;
   endproperty
   a_osc_amp: assert property (p_osc_amp) else $error("amp mode");
   // config outputs only move after a bus access
   property p_pull_hold; !$past(wbReq.cyc) && !$past(wbReq.cyc, 2) |-> $stable(pad.pullEn);
   endproperty
   a_pull_hold: assert property (p_pull_hold) else $error("pull-up moved");
   property p_pll_hold; !$past(wbReq.cyc) && !$past(wbReq.cyc, 2) |-> $stable(coreClkFromPll);
   endproperty
   a_pll_hold: assert property (p_pll_hold) else $error("pll select moved");
   c_write: cover property (wbRsp.ack && wbReq.we);
   c_busy: cover property (emiBusActive);
   c_clock_output_pin: cover property (!clockOutputPinOe_b && clockOutputPin);
endmodule // agcpm_pin_mux_monitor
bind agcpm_pin_mux agcpm_pin_mux_monitor mon (.clock(clock), .rst_b(rst_b), .wbReq(wbReq),
   .wbRsp(wbRsp), .emiBusActive(emiBusActive), .emiCtrlOe_b(emiCtrlOe_b), .pad(pad),
   .clockOutputPin(clockOutputPin), .clockOutputPinOe_b(clockOutputPinOe_b),
   .clockInputModePin(clockInputModePin), .oscAmpEnable(oscAmpEnable),
   .coreClkFromPll(coreClkFromPll));

// ---- test/agcpm_mem_model.sv ----
// external memory on the shared pins, with wire resolution
`timescale 1ns/10ps
module agcpm_mem_model
   import agcpm_pkg::*;
(
   // clock
   input wire logic clock,
   // device pads and strobe enable
   input wire agcpm_pkg::agcpm_pad_s pad,
   input wire logic ctrlOe_b,
   // board drivers on port pins
   input wire logic [5:0] extVal,
   input wire logic [5:0] extEn,
   // wire levels and latched address
   output logic [5:0] wireLvl,
   output logic [5:0] lastAddr
);
   logic [5:0] prevLvl = 6'h00; // last level, for released wires
   // released wire without pull-up flips, so a stale value never matches
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (extEn[i]) wireLvl[i] = extVal[i];
         else if (!pad.oe_b[i]) wireLvl[i] = pad.out[i];
         else if (pad.pullEn[i]) wireLvl[i] = 1'b1;
         else wireLvl[i] = ~prevLvl[i];
      end
   end
   // memory latches the address while strobes are live
   always @(posedge clock) begin
      prevLvl <= wireLvl;
      if (!ctrlOe_b) lastAddr <= wireLvl;
   end
endmodule // agcpm_mem_model

// ---- test/tb_address_gpio_clock_out_pin_mux.sv ----
// bench for the address/port pin mux
`timescale 1ns/10ps
module tb_address_gpio_clock_out_pin_mux;
   import agcpm_pkg::*;
   logic clock, rst_b, emiBusActive, emiCtrlOe_b, clockOutputPin, clockOutputPinOe_b;
   logic clockInputModePin, oscAmpEnable, coreClkFromPll;
   logic [5:0] emiAddr, padIn, extVal, extEn, lastAddr;
   agcpm_wb_req_s wbReq;
   agcpm_wb_rsp_s wbRsp;
   agcpm_pad_s pad;
   agcpm_clk_src_s clkSrc;
   int errors, checkCount;
   agcpm_pin_mux dut (.clock(clock), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
      .emiAddr(emiAddr), .emiBusActive(emiBusActive), .emiCtrlOe_b(emiCtrlOe_b),
      .padIn(padIn), .pad(pad), .clkSrc(clkSrc), .clockOutputPin(clockOutputPin),
      .clockOutputPinOe_b(clockOutputPinOe_b), .clockInputModePin(clockInputModePin),
      .oscAmpEnable(oscAmpEnable), .coreClkFromPll(coreClkFromPll));
   agcpm_mem_model mem (.clock(clock), .pad(pad), .ctrlOe_b(emiCtrlOe_b), .extVal(extVal),
      .extEn(extEn), .wireLvl(padIn), .lastAddr(lastAddr));
   always #2 clock = ~clock;
   task automatic summarize();
      $display("checks %0d errors %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic cycle; held until ack is sampled, bounded wait
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
      output logic [31:0] rdat);
      int n;
      n = 0;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
      do begin
         @(posedge clock);
         n++;
      end while (wbRsp.ack !== 1'b1 && n < 20);
      rdat = wbRsp.dat;
      wbReq <= '0;
      if (n >= 20) begin
         errors++;
         summarize();
      end
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] v;
      wb(1'b1, adr, d, v);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] v;
      wb(1'b0, adr, 32'h0, v);
      chk(v, exp);
   endtask
   initial begin
      clock = 0; rst_b = 0; wbReq = '0; emiAddr = '0; emiBusActive = 0; clkSrc = '0;
      clockInputModePin = 0; extVal = '0; extEn = '0; errors = 0; checkCount = 0;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      chk(32'(pad.oe_b), 32'h3F);
      chk(32'(clockOutputPinOe_b), 32'h1);
      rd(OFS_FUNC_SEL, 32'h3F00);
      rd(OFS_PORT_DIR, 32'h0);
      rd(OFS_PULLUP, 32'h3F00);
      rd(OFS_BUS_CTRL, 32'h0);
      rd(8'h40, 32'h0);
      // address phase with floating idle
      emiAddr <= 6'h2A;
      emiBusActive <= 1'b1;
      repeat (3) @(posedge clock);
      chk(32'(pad.out), 32'h2A);
      chk(32'(lastAddr), 32'h2A);
      emiBusActive <= 1'b0;
      repeat (2) @(posedge clock);
      chk(32'(pad.oe_b), 32'h3F);
      wr(OFS_BUS_CTRL, 32'h1);
      chk(32'(pad.oe_b), 32'h0);
      // pins 0-2 address, 3-4 outputs, 5 input driven by the board
      wr(OFS_FUNC_SEL, 32'h0700);
      wr(OFS_PORT_DIR, 32'h1800);
      wr(OFS_PORT_OUT, 32'h0800);
      emiAddr <= 6'h15;
      extVal <= 6'h20;
      extEn <= 6'h20;
      repeat (4) @(posedge clock);
      chk(32'(pad.oe_b), 32'h20);
      chk(32'(pad.out), 32'h0D);
      rd(OFS_PORT_IN, 32'h2D00);
      wr(OFS_PULLUP, 32'h3E00);
      chk(32'(pad.pullEn), 32'h3E);
      // every source code, selected one high, then all others high
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CLOCK_OUTPUT_PIN_SEL, 32'(i));
         clkSrc <= (i == 0) ? 7'h7F : 7'(8'h80 >> i);
         repeat (3) @(posedge clock);
         chk(32'(clockOutputPin), 32'(i != 0));
         chk(32'(clockOutputPinOe_b), 32'(i == 0));
         clkSrc <= ~clkSrc;
         repeat (3) @(posedge clock);
         chk(32'(clockOutputPin), 32'h0);
      end
      wr(OFS_CLK_CFG, 32'h1);
      chk(32'(coreClkFromPll), 32'h1);
      rd(OFS_CLK_CFG, 32'h1);
      chk(32'(oscAmpEnable), 32'h1);
      // board switches to an external clock by raising the mode pin
      clockInputModePin <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(oscAmpEnable), 32'h0);
      rd(OFS_CLK_CFG, 32'h3);
      wr(OFS_CLK_CFG, 32'h0);
      chk(32'(coreClkFromPll), 32'h0);
      summarize();
   end
endmodule // tb_address_gpio_clock_out_pin_mux
